// ==== src/sad_consts.vh ====
`ifndef SAD_CONSTS_VH
`define SAD_CONSTS_VH

// Variant selection codes
`define SAD_VAR_LARGE       2'h0
`define SAD_VAR_MID         2'h1
`define SAD_VAR_SMALL       2'h2
`define SAD_VAR_NONE        2'h3

// Single-access RAM, CPU byte addresses (24 bits)
`define SAD_RAM_CPU_BASE    24'h010000
`define SAD_RAM_CPU_END_MID 24'h03FFFF
`define SAD_RAM_CPU_END_SML 24'h01FFFF
`define SAD_RAM_BLKS_MID    6'h18
`define SAD_RAM_BLKS_SML    6'h08
// Block index sits at bits [17:13]: 8K bytes per block
`define SAD_RAM_BLK_LSB     13

// DMA/USB byte map (32 bits)
`define SAD_RAM_DMA_BASE    32'h00090000

// I/O space word addresses (16 bits, 64K)
`define SAD_IO_IDLE_END     16'h0004
`define SAD_IO_RSV0_LO      16'h0005
`define SAD_IO_RSV0_HI      16'h0BFF
`define SAD_IO_RSV1_LO      16'h1D00
`define SAD_IO_RSV1_HI      16'h27FF
`define SAD_IO_RSV2_LO      16'h10EE
`define SAD_IO_RSV2_HI      16'h17FF
`define SAD_IO_ANA_LO       16'h7000
`define SAD_IO_ANA_HI       16'h70FF
`define SAD_IO_I2C_LO       16'h1A00
`define SAD_IO_I2C_HI       16'h1A6C
`define SAD_IO_UART_LO      16'h1B00
`define SAD_IO_UART_HI      16'h1B1F
`define SAD_IO_SYS_LO       16'h1C00
`define SAD_IO_SYS_HI       16'h1CFF
`define SAD_IO_I2S_LO       16'h2800
`define SAD_IO_I2S_HI       16'h2B40
`define SAD_IO_SD_LO        16'h3A00
`define SAD_IO_SD_HI        16'h3B7F
`define SAD_IO_USB_LO       16'h8000

// I/O decode result codes
`define SAD_IO_SEL_NONE     3'h0
`define SAD_IO_SEL_I2C      3'h1
`define SAD_IO_SEL_UART     3'h2
`define SAD_IO_SEL_I2S      3'h3
`define SAD_IO_SEL_SD       3'h4
`define SAD_IO_SEL_USB      3'h5
`define SAD_IO_SEL_ANA      3'h6
`define SAD_IO_SEL_OTHER    3'h7

`endif

// ==== src/sad_rr_arb.v ====
`timescale 1ns/1ns
// Round-robin arbiter for one RAM block; grant is one-hot
module sad_rr_arb #(
  parameter N = 4
) (
  // Clock and reset
  input  wire         clk_sys_i,
  input  wire         rst_n_i,
  // Requests and grant
  input  wire [N-1:0] req_i,
  output reg  [N-1:0] gnt_o
);
  reg [N-1:0] last_reg;
  reg [N-1:0] gnt_next;
  integer     i;
  integer     k;
  reg         found;

  // Search starts just after the last winner so no master starves
  always @* begin
    gnt_next = {N{1'b0}};
    found    = 1'b0;
    k        = 0;
    for (i = 0; i < N; i = i + 1) begin
      if (last_reg[i])
        k = i;
    end
    for (i = 1; i <= N; i = i + 1) begin
      if (!found && req_i[(k + i) % N]) begin
        gnt_next[(k + i) % N] = 1'b1;
        found                 = 1'b1;
      end
    end
    gnt_o = gnt_next;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      last_reg <= {{(N-1){1'b0}}, 1'b1};
    else if (found)
      last_reg <= gnt_next;
  end
endmodule

// ==== src/sad_decode.v ====
`timescale 1ns/1ns
`include "sad_consts.vh"
module sad_decode #(
  parameter NBLK = 24,
  parameter AW   = 12
) (
  // Clock, reset, variant strap
  input  wire                 clk_sys_i,
  input  wire                 rst_n_i,
  input  wire [1:0]           variant_i,
  // CPU program bus (byte address)
  input  wire                 prog_req_i,
  input  wire [23:0]          prog_addr_i,
  // CPU data bus (byte address)
  input  wire                 data_req_i,
  input  wire                 data_we_i,
  input  wire [23:0]          data_addr_i,
  // DMA bus: RAM map or I/O space
  input  wire                 dma_req_i,
  input  wire                 dma_we_i,
  input  wire                 dma_io_i,
  input  wire                 dma_io_allow_i,
  input  wire [31:0]          dma_addr_i,
  // USB master bus
  input  wire                 usb_req_i,
  input  wire                 usb_we_i,
  input  wire [31:0]          usb_addr_i,
  // CPU I/O opcode port (word address)
  input  wire                 cpu_io_req_i,
  input  wire [15:0]          cpu_io_addr_i,
  // Grants and stalls: bit0 prog, 1 data, 2 dma, 3 usb
  output reg  [3:0]           gnt_o,
  output reg  [3:0]           stall_o,
  output reg  [3:0]           err_o,
  // RAM block strobes
  output reg  [NBLK-1:0]      ram_en_o,
  output reg                  ram_we_o,
  output reg  [AW-1:0]        ram_addr_o,
  // I/O window selection
  output reg  [2:0]           io_sel_o,
  output reg  [15:0]          io_addr_o,
  output reg                  io_from_dma_o,
  output reg                  io_err_o
);
  localparam NM = 4;

  // CPU map to block index, valid flag
  function [6:0] cpu_blk;
    input [23:0] a;
    input [1:0]  v;
    reg   [23:0] lim;
    reg   [23:0] off;
    begin
      lim = (v == `SAD_VAR_SMALL) ? `SAD_RAM_CPU_END_SML : `SAD_RAM_CPU_END_MID;
      off = (a - `SAD_RAM_CPU_BASE) >> `SAD_RAM_BLK_LSB;
      if (v != `SAD_VAR_NONE && a >= `SAD_RAM_CPU_BASE && a <= lim)
        cpu_blk = {1'b1, off[5:0]};
      else
        cpu_blk = 7'h00;
    end
  endfunction

  // DMA/USB map folds onto the CPU map
  function [23:0] dma_to_cpu;
    input [31:0] a;
    reg   [31:0] d;
    begin
      d = a - `SAD_RAM_DMA_BASE;
      if (a >= `SAD_RAM_DMA_BASE && d < 32'h00FF0000)
        dma_to_cpu = d[23:0] + `SAD_RAM_CPU_BASE;
      else
        dma_to_cpu = 24'h000000;
    end
  endfunction

  // I/O space decode
  function [2:0] io_dec;
    input [15:0] a;
    input [1:0]  v;
    begin
      if (a >= `SAD_IO_RSV0_LO && a <= `SAD_IO_RSV0_HI)
        io_dec = `SAD_IO_SEL_NONE;
      else if (a >= `SAD_IO_RSV1_LO && a <= `SAD_IO_RSV1_HI)
        io_dec = `SAD_IO_SEL_NONE;
      else if (v != `SAD_VAR_LARGE && a >= `SAD_IO_RSV2_LO && a <= `SAD_IO_RSV2_HI)
        io_dec = `SAD_IO_SEL_NONE;
      else if (a >= `SAD_IO_I2C_LO && a <= `SAD_IO_I2C_HI)
        io_dec = `SAD_IO_SEL_I2C;
      else if (a >= `SAD_IO_UART_LO && a <= `SAD_IO_UART_HI)
        io_dec = `SAD_IO_SEL_UART;
      else if (a >= `SAD_IO_I2S_LO && a <= `SAD_IO_I2S_HI)
        io_dec = `SAD_IO_SEL_I2S;
      else if (a >= `SAD_IO_SD_LO && a <= `SAD_IO_SD_HI)
        io_dec = `SAD_IO_SEL_SD;
      else if (v == `SAD_VAR_LARGE && a >= `SAD_IO_ANA_LO && a <= `SAD_IO_ANA_HI)
        io_dec = `SAD_IO_SEL_ANA;
      else if (v != `SAD_VAR_SMALL && a >= `SAD_IO_USB_LO)
        io_dec = `SAD_IO_SEL_USB;
      else
        io_dec = `SAD_IO_SEL_OTHER;
    end
  endfunction

  // Per master decode
  reg  [6:0]      blk      [0:NM-1];
  reg  [23:0]     cpu_addr [0:NM-1];
  reg  [NM-1:0]   ram_req;
  reg  [NM-1:0]   we;
  reg  [NM-1:0]   miss;
  reg  [NM-1:0]   gnt_all;
  reg  [NM-1:0]   stall_all;
  reg  [NBLK-1:0] en_next;
  reg             we_next;
  reg  [AW-1:0]   addr_next;
  wire [NM-1:0]   gnt_blk  [0:NBLK-1];
  reg  [NM-1:0]   req_blk  [0:NBLK-1];
  integer         m;
  integer         b;
  integer         gm;
  integer         gb;

  always @* begin
    cpu_addr[0] = prog_addr_i;
    cpu_addr[1] = data_addr_i;
    cpu_addr[2] = dma_to_cpu(dma_addr_i);
    cpu_addr[3] = dma_to_cpu(usb_addr_i);
    we          = {usb_we_i, dma_we_i & ~dma_io_i, data_we_i, 1'b0};
    ram_req     = {usb_req_i, dma_req_i & ~dma_io_i, data_req_i, prog_req_i};
    for (m = 0; m < NM; m = m + 1) begin
      blk[m]  = cpu_blk(cpu_addr[m], variant_i);
      miss[m] = ram_req[m] & ~blk[m][6];
    end
    for (b = 0; b < NBLK; b = b + 1) begin
      for (m = 0; m < NM; m = m + 1)
        req_blk[b][m] = ram_req[m] & blk[m][6] & (blk[m][5:0] == b[5:0]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NBLK; g = g + 1) begin : arb
      sad_rr_arb #(.N(NM)) u_arb (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .req_i     (req_blk[g]),
        .gnt_o     (gnt_blk[g])
      );
    end
  endgenerate

  // One grant per block keeps each block to a single access
  always @* begin
    gnt_all   = {NM{1'b0}};
    en_next   = {NBLK{1'b0}};
    we_next   = 1'b0;
    addr_next = {AW{1'b0}};
    for (gb = 0; gb < NBLK; gb = gb + 1) begin
      for (gm = 0; gm < NM; gm = gm + 1) begin
        if (gnt_blk[gb][gm]) begin
          gnt_all[gm] = 1'b1;
          en_next[gb] = 1'b1;
          we_next     = we[gm];
          addr_next   = cpu_addr[gm][AW:1];
        end
      end
    end
    stall_all = ram_req & ~gnt_all & ~miss;
  end

  // I/O path: CPU opcodes win over DMA; DMA only to its windows
  reg [2:0]  io_sel_c;
  reg        io_dma_c;
  reg        io_err_c;
  reg [15:0] io_addr_c;
  reg        dma_io_stall;
  always @* begin
    io_dma_c     = 1'b0;
    io_err_c     = 1'b0;
    dma_io_stall = 1'b0;
    io_addr_c    = cpu_io_addr_i;
    io_sel_c     = `SAD_IO_SEL_NONE;
    if (cpu_io_req_i) begin
      io_sel_c = io_dec(cpu_io_addr_i, variant_i);
      io_err_c = (io_sel_c == `SAD_IO_SEL_NONE);
      dma_io_stall = dma_req_i & dma_io_i;
    end else if (dma_req_i && dma_io_i) begin
      io_addr_c = dma_addr_i[15:0];
      io_sel_c  = io_dec(dma_addr_i[15:0], variant_i);
      io_dma_c  = 1'b1;
      if (!dma_io_allow_i || io_sel_c == `SAD_IO_SEL_OTHER || io_sel_c == `SAD_IO_SEL_NONE) begin
        io_sel_c = `SAD_IO_SEL_NONE;
        io_err_c = 1'b1;
      end
    end
  end

  // Registered outputs; the peripheral reset and clock gate are the master's job
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gnt_o         <= 4'h0;
      stall_o       <= 4'h0;
      err_o         <= 4'h0;
      ram_en_o      <= {NBLK{1'b0}};
      ram_we_o      <= 1'b0;
      ram_addr_o    <= {AW{1'b0}};
      io_sel_o      <= 3'h0;
      io_addr_o     <= 16'h0000;
      io_from_dma_o <= 1'b0;
      io_err_o      <= 1'b0;
    end else begin
      gnt_o         <= gnt_all | {1'b0, io_dma_c & ~io_err_c, 2'h0};
      stall_o       <= stall_all | {1'b0, dma_io_stall, 2'h0};
      err_o         <= miss | {1'b0, io_dma_c & io_err_c, 2'h0};
      ram_en_o      <= en_next;
      ram_we_o      <= we_next;
      ram_addr_o    <= addr_next;
      io_sel_o      <= io_sel_c;
      io_addr_o     <= io_addr_c;
      io_from_dma_o <= io_dma_c;
      io_err_o      <= io_err_c;
    end
  end
endmodule

// ==== bench/sad_master.sv ====
`timescale 1ns/1ns
// Bus master stand-in: one-cycle request, reissued after a stall
module sad_master #(
  parameter W = 32
) (
  // Clock
  input  wire         clk_sys_i,
  // Bench command and decoder answer
  input  wire         start_i,
  input  wire [31:0]  addr_i,
  input  wire         stall_i,
  // Request towards the decoder
  output reg          req_o,
  output reg  [W-1:0] addr_o
);
  initial req_o = 1'b0;
  initial addr_o = {W{1'b0}};
  // Targets are taken as already out of reset and clocked before any access
  always @(posedge clk_sys_i) begin
    req_o <= start_i | stall_i;
    if (start_i) begin
      addr_o <= addr_i[W-1:0];
    end else if (!req_o && !stall_i) begin
      // Idle bus churns from its second idle cycle, so the old address comes back every other cycle
      addr_o <= ~addr_o;
    end
  end
endmodule

// ==== bench/sad_decode_props.sv ====
`timescale 1ns/1ns
module sad_decode_props #(
  parameter NBLK = 24,
  parameter AW   = 12
) (
  // Clock and reset
  input wire            clk_sys_i,
  input wire            rst_n_i,
  // Requests
  input wire [1:0]      variant_i,
  input wire            prog_req_i,
  input wire [23:0]     prog_addr_i,
  input wire            data_req_i,
  input wire [23:0]     data_addr_i,
  input wire            dma_req_i,
  input wire            dma_io_i,
  input wire            dma_io_allow_i,
  input wire            usb_req_i,
  input wire            cpu_io_req_i,
  input wire [15:0]     cpu_io_addr_i,
  // Answers
  input wire [3:0]      gnt_o,
  input wire [3:0]      stall_o,
  input wire [3:0]      err_o,
  input wire [NBLK-1:0] ram_en_o,
  input wire [AW-1:0]   ram_addr_o,
  input wire [2:0]      io_sel_o,
  input wire            io_err_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire [15:0] ca  = cpu_io_addr_i;
  wire        cio = cpu_io_req_i && !(dma_req_i && dma_io_i);
  wire        mid = variant_i == 2'h1;
  a_one_access: assert property ($countones(ram_en_o) <= $countones(gnt_o))
    else $error("more blocks enabled than grants");
  a_walk_first: assert property (prog_req_i && prog_addr_i == 24'h010000 && !data_req_i && !dma_req_i && !usb_req_i
    && mid |=> gnt_o[0] && ram_en_o[0] && ram_addr_o == 0) else $error("first block not granted");
  a_contend_one: assert property (prog_req_i && data_req_i && prog_addr_i[23:13] == data_addr_i[23:13] && mid &&
    prog_addr_i >= 24'h010000 && prog_addr_i <= 24'h03FFFF && !dma_req_i && !usb_req_i
    |=> $countones(gnt_o[1:0]) == 1 && stall_o[1:0] == ~gnt_o[1:0]) else $error("contention wrong");
  a_answer_once: assert property (prog_req_i |=> $countones({gnt_o[0], stall_o[0], err_o[0]}) == 1)
    else $error("program request not answered once");
  a_rsv_low: assert property (cio && ca >= 16'h0005 && ca <= 16'h0BFF |=> io_err_o)
    else $error("low reserved io accepted");
  a_rsv_sys: assert property (cio && ca >= 16'h1D00 && ca <= 16'h27FF |=> io_err_o)
    else $error("reserved io after system window accepted");
  a_rsv_timer: assert property (cio && variant_i != 2'h0 && ca >= 16'h10EE && ca <= 16'h17FF |=> io_err_o)
    else $error("reserved io below timers accepted");
  a_ana_large: assert property (cio && variant_i == 2'h0 && ca[15:8] == 8'h70 |=> io_sel_o == 3'h6)
    else $error("converter window not selected");
  a_dma_refuse: assert property (dma_req_i && dma_io_i && !dma_io_allow_i && !cpu_io_req_i |=> err_o[2])
    else $error("dma io without permission accepted");
endmodule
bind sad_decode sad_decode_props #(.NBLK(NBLK), .AW(AW)) u_props (.*);

// ==== bench/single_access_ram_and_io_space_decode_test.sv ====
`timescale 1ns/1ns
module single_access_ram_and_io_space_decode_test;
  reg         clk_sys_i = 1'b0;
  reg         rst_n_i   = 1'b0;
  reg  [1:0]  var_r     = 2'h1;
  reg  [4:0]  st        = 5'h0;
  reg  [31:0] a         = 32'h0;
  reg  [3:0]  we        = 4'h0;
  reg         io_r      = 1'b0;
  reg         allow     = 1'b0;
  wire [4:0]  req;
  wire [31:0] ad [0:4];
  wire [3:0]  gnt, stl, err;
  wire [23:0] en;
  wire [11:0] ra;
  wire [15:0] ioa;
  wire [2:0]  sel;
  wire        rwe, ioe, iod;
  wire [4:0]  stl5 = {1'b0, stl};
  integer     num_errors = 0;
  integer     total_checks = 0;
  integer     i, m, b, w, n, g0, g1;
  localparam [95:0] RSV = {16'h0005, 16'h0BFF, 16'h1D00, 16'h27FF, 16'h10EE, 16'h17FF};
  initial forever #4 clk_sys_i = ~clk_sys_i;
  genvar k;
  for (k = 0; k < 5; k = k + 1) begin : g_m
    sad_master u_m (.clk_sys_i(clk_sys_i), .start_i(st[k]), .addr_i(a), .stall_i(stl5[k]), .req_o(req[k]),
                    .addr_o(ad[k]));
  end
  sad_decode DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .variant_i(var_r),
    .prog_req_i(req[0]), .prog_addr_i(ad[0][23:0]), .data_req_i(req[1]), .data_we_i(we[1]),
    .data_addr_i(ad[1][23:0]), .dma_req_i(req[2]), .dma_we_i(we[2]), .dma_io_i(io_r), .dma_io_allow_i(allow),
    .dma_addr_i(ad[2]), .usb_req_i(req[3]), .usb_we_i(we[3]), .usb_addr_i(ad[3]), .cpu_io_req_i(req[4]),
    .cpu_io_addr_i(ad[4][15:0]), .gnt_o(gnt), .stall_o(stl), .err_o(err), .ram_en_o(en), .ram_we_o(rwe),
    .ram_addr_o(ra), .io_sel_o(sel), .io_addr_o(ioa), .io_from_dma_o(iod), .io_err_o(ioe));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task rst(input [1:0] v);
    begin
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      var_r <= v;
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
    end
  endtask
  // Returns one cycle after the start edge; the answer lands two edges later
  task fire(input [4:0] mk, input [31:0] adr, input [3:0] wv);
    begin
      @(posedge clk_sys_i);
      st <= mk;
      a <= adr;
      we <= wv;
      @(posedge clk_sys_i);
      st <= 5'h0;
    end
  endtask
  task nxt;
    begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  task io(input integer kk, input [15:0] adr, input al);
    begin
      @(posedge clk_sys_i);
      io_r <= 1'b1;
      allow <= al;
      fire(5'h1 << kk, adr, 4'h0);
      nxt;
    end
  endtask
  task ram_run(input integer nb);
    begin
      for (i = 0; i < 16; i = i + 1) begin
        m = $urandom_range(3);
        b = $urandom_range(nb + 1);
        w = $urandom_range(12'hFFF);
        n = $urandom;
        fire(5'h1 << m, (m < 2 ? 32'h010000 : 32'h00090000) + b * 8192 + w * 2, n);
        nxt;
        if (b < nb) begin
          chk(gnt, 4'h1 << m);
          chk(en, 24'h1 << b);
          chk(ra, w);
          chk(rwe, m > 0 && n[m]);
        end else
          chk(err, 4'h1 << m);
      end
      $display("test ram map done");
    end
  endtask
  initial begin
    #160000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    n = $urandom(32);
    rst(2'h1);
    fire(5'h1, 32'h010000, 4'h0);
    nxt;
    chk({gnt, en, ra}, {4'h1, 24'h1, 12'h0});
    ram_run(24);
    fire(5'h3, 32'h010000 + $urandom_range(23) * 8192, 4'h0);
    g0 = 0;
    g1 = 0;
    n = 0;
    repeat (5) begin
      nxt;
      g0 = g0 + gnt[0];
      g1 = g1 + gnt[1];
      n = n + stl[0] + stl[1];
    end
    chk({g0[3:0], g1[3:0], n[3:0]}, 12'h111);
    $display("test contention done");
    for (i = 0; i < 6; i = i + 1) begin
      io(4, RSV[i * 16 +: 16], 1'b0);
      chk(ioe, 1);
    end
    io(4, 16'h1A00, 1'b0);
    chk({sel, ioe}, {3'h1, 1'b0});
    chk(ioa, 16'h1A00);
    io(2, 16'h1B00, 1'b1);
    chk({sel, iod}, {3'h2, 1'b1});
    chk(ioa, 16'h1B00);
    io(2, 16'h1C00, 1'b1);
    chk(err[2], 1);
    io(2, 16'h1A00, 1'b0);
    chk(err[2], 1);
    // CPU and DMA hit I/O together: CPU goes first, DMA retries once stalled
    @(posedge clk_sys_i);
    allow <= 1'b1;
    fire(5'h14, 32'h1A00, 4'h0);
    nxt;
    chk({stl[2], iod, sel}, {1'b1, 1'b0, 3'h1});
    nxt;
    nxt;
    chk({gnt[2], iod, sel}, {1'b1, 1'b1, 3'h1});
    $display("test io space done");
    rst(2'h0);
    io(4, 16'h7000, 1'b0);
    chk(sel, 3'h6);
    io(4, 16'h70FF, 1'b0);
    chk(sel, 3'h6);
    $display("test large variant done");
    @(posedge clk_sys_i);
    io_r <= 1'b0;
    rst(2'h2);
    ram_run(8);
    end_sim;
  end
endmodule
